// ---- hdl/mode_map_pkg.sv ----
package mode_map_pkg;

  // Operating modes, captured once after reset
  typedef enum logic [1:0] {
    MODE_BOOT,
    MODE_TEST,
    MODE_SINGLE,
    MODE_EXPANDED
  } op_mode_type;

  // Mode select pin pairs {b, a}
  localparam logic [1:0] MODE_PINS_BOOT   = 2'h0;
  localparam logic [1:0] MODE_PINS_TEST   = 2'h1;
  localparam logic [1:0] MODE_PINS_SINGLE = 2'h2;

  // Memory map
  localparam logic [15:0] RAM_SIZE       = 16'h0400;
  localparam logic [15:0] REG_SIZE       = 16'h0060;
  localparam logic [15:0] EE_SIZE        = 16'h0200;
  localparam logic [15:0] BOOT_SIZE      = 16'h0100;
  localparam logic [15:0] HOLE_SIZE      = 16'h0100;
  localparam logic [15:0] BOOT_BASE      = 16'hbf00;
  localparam logic [11:0] EE_PAGE_OFS    = 12'he00;
  localparam logic [11:0] HOLE_PAGE_OFS  = 12'hd00;
  localparam logic [11:0] PAGE_ZERO_OFS  = 12'h000;
  localparam logic [15:0] VECTOR_BASE    = 16'hffc0;
  localparam logic [15:0] BOOT_VEC_BASE  = 16'hbfc0;
  localparam logic [15:0] RAM_LAST       = 16'h03ff;
  localparam logic [15:0] RAM_ENTRY      = 16'h0000;
  localparam int          VEC_OFS_W      = 6;

  // Reset values of page fields
  localparam logic [3:0]  RAM_PAGE_RST   = 4'h0;
  localparam logic [3:0]  REG_PAGE_RST   = 4'h1;
  localparam logic [3:0]  EE_PAGE_DEF    = 4'hf;
  localparam logic [7:0]  CONFIG_RST     = 8'hff;

  // Field positions
  localparam int INIT_RAM_LSB   = 4;
  localparam int INIT_REG_LSB   = 0;
  localparam int CFG_EE_LSB     = 4;
  localparam int CFG_EEON_BIT   = 0;
  localparam int CTRL_STOP_BIT  = 0;
  localparam int ST_STOP_BIT    = 2;
  localparam int ST_BOOTDN_BIT  = 3;
  localparam int ST_EEEN_BIT    = 4;

  // Register byte addresses on the bus
  localparam logic [3:0] INIT_OFS    = 4'h0;
  localparam logic [3:0] CONFIG_OFS  = 4'h4;
  localparam logic [3:0] STATUS_OFS  = 4'h8;
  localparam logic [3:0] CONTROL_OFS = 4'hc;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // Bootloader idle timeout: four characters of ten bits
  localparam int CHAR_BITS    = 10;
  localparam int IDLE_CHARS   = 4;
  localparam int BAUD_DEFAULT = 7812;
  localparam int CLK_HZ       = 50000000;
  localparam int IDLE_CYCLES  = (CLK_HZ / BAUD_DEFAULT) * CHAR_BITS * IDLE_CHARS;

  // Decoded selects
  typedef struct packed {
    logic ram;
    logic regs;
    logic eeprom;
    logic boot;
    logic ext;
  } sel_type;

  // CPU access request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        vector;
    logic        direct;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cpu_req_type;

endpackage : mode_map_pkg

// ---- hdl/window_match.sv ----
`timescale 1ns/1ns
module window_match (
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] base_i,
  input  wire logic [15:0] size_i,
  input  wire logic        enable_i,
  output logic             hit_o
);
  import mode_map_pkg::*;

  logic [15:0] delta;

  // Window hit: base <= addr < base + size
  always_comb begin
    delta = addr_i - base_i;
    hit_o = enable_i && (addr_i >= base_i) && (delta < size_i);
  end

endmodule : window_match

// ---- hdl/config_store.sv ----
`timescale 1ns/1ns
module config_store (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       prog_en_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] config_o
);
  import mode_map_pkg::*;

  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;

  // Separate config byte, loaded with CONFIG_RST at reset, written only while programming is allowed
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_i && prog_en_i) begin
      cfg_nxt = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r <= CONFIG_RST;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign config_o = cfg_r;

endmodule : config_store

// ---- hdl/mode_select_memory_map_decoder.sv ----
`timescale 1ns/1ns
module mode_select_memory_map_decoder #(
  parameter int IDLE_LIMIT = mode_map_pkg::IDLE_CYCLES
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  // Mode pins
  input  wire logic                       mode_select_a_i,
  input  wire logic                       mode_select_b_i,
  // AHB-Lite slave
  input  wire logic                       hsel_i,
  input  wire logic [31:0]                haddr_i,
  input  wire logic [1:0]                 htrans_i,
  input  wire logic                       hwrite_i,
  input  wire logic [2:0]                 hsize_i,
  input  wire logic [31:0]                hwdata_i,
  input  wire logic                       hready_i,
  output logic      [31:0]                hrdata_o,
  output logic                            hreadyout_o,
  output logic                            hresp_o,
  // CPU side
  input  wire mode_map_pkg::cpu_req_type  cpu_req_i,
  output mode_map_pkg::sel_type           sel_o,
  output logic      [15:0]                mapped_addr_o,
  output logic      [7:0]                 ext_rdata_o,
  // Expansion ports
  input  wire logic [7:0]                 gpio_b_out_i,
  input  wire logic [7:0]                 gpio_b_dir_i,
  input  wire logic [7:0]                 gpio_f_out_i,
  input  wire logic [7:0]                 gpio_f_dir_i,
  input  wire logic [7:0]                 gpio_c_out_i,
  input  wire logic [7:0]                 gpio_c_dir_i,
  input  wire logic [7:0]                 port_c_i,
  output logic      [7:0]                 port_b_o,
  output logic      [7:0]                 port_b_oe_n_o,
  output logic      [7:0]                 port_f_o,
  output logic      [7:0]                 port_f_oe_n_o,
  output logic      [7:0]                 port_c_o,
  output logic      [7:0]                 port_c_oe_n_o,
  output logic                            rw_n_o,
  // Serial transmit pin and received-byte strobe
  input  wire logic                       txd_data_i,
  input  wire logic                       rx_byte_i,
  output logic                            txd_o,
  output logic                            txd_oe_n_o,
  // Boot and power control
  output logic                            boot_jump_o,
  output logic      [15:0]                boot_entry_o,
  output logic                            vectors_in_ram_o,
  output logic                            clk_halt_o,
  input  wire logic                       wake_i,
  output mode_map_pkg::op_mode_type       mode_o
);
  import mode_map_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Mode capture and memory-init state

  op_mode_type mode_r;
  op_mode_type mode_nxt;
  logic        captured_r;
  logic        captured_nxt;
  logic [3:0]  ram_page_r;
  logic [3:0]  ram_page_nxt;
  logic [3:0]  reg_page_r;
  logic [3:0]  reg_page_nxt;
  logic        ee_en_r;
  logic        ee_en_nxt;
  logic        stop_r;
  logic        stop_nxt;
  logic        wr_init;
  logic        wr_config;
  logic        wr_control;
  logic [7:0]  config_byte;
  logic        boot_done_r;
  logic        boot_done_nxt;

  always_comb begin
    mode_nxt     = mode_r;
    captured_nxt = 1'b1;
    ram_page_nxt = ram_page_r;
    reg_page_nxt = reg_page_r;
    ee_en_nxt    = ee_en_r;
    stop_nxt     = stop_r;
    if (!captured_r) begin
      unique case ({mode_select_b_i, mode_select_a_i})
        MODE_PINS_BOOT:   mode_nxt = MODE_BOOT;
        MODE_PINS_TEST:   mode_nxt = MODE_TEST;
        MODE_PINS_SINGLE: mode_nxt = MODE_SINGLE;
        default:          mode_nxt = MODE_EXPANDED;
      endcase
      ee_en_nxt = !({mode_select_b_i, mode_select_a_i} == MODE_PINS_TEST);
    end
    if (wr_init) begin
      ram_page_nxt = hwdata_i[INIT_RAM_LSB +: 4];
      reg_page_nxt = hwdata_i[INIT_REG_LSB +: 4];
    end
    if (wr_config && mode_r == MODE_TEST) begin
      ee_en_nxt = hwdata_i[CFG_EEON_BIT];
    end
    if (wr_control && hwdata_i[CTRL_STOP_BIT]) begin
      stop_nxt = 1'b1;
    end else if (wake_i) begin
      stop_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r     <= MODE_SINGLE;
      captured_r <= 1'b0;
      ram_page_r <= RAM_PAGE_RST;
      reg_page_r <= REG_PAGE_RST;
      ee_en_r    <= 1'b1;
      stop_r     <= 1'b0;
    end else begin
      mode_r     <= mode_nxt;
      captured_r <= captured_nxt;
      ram_page_r <= ram_page_nxt;
      reg_page_r <= reg_page_nxt;
      ee_en_r    <= ee_en_nxt;
      stop_r     <= stop_nxt;
    end
  end

  config_store u_config_store (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .prog_en_i (mode_r == MODE_TEST),
    .wr_i      (wr_config),
    .wdata_i   (hwdata_i[7:0]),
    .config_o  (config_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic        normal_mode;
  logic        bus_mode;
  logic        ee_on;
  logic [3:0]  eeprom_page_field;
  logic [15:0] cpu_addr;
  logic [15:0] ram_base;
  logic [15:0] reg_base;
  logic [15:0] ee_base;
  logic [15:0] hole_base;
  logic        hit_ram;
  logic        hit_reg;
  logic        hit_ee;
  logic        hit_boot;
  logic        hit_hole;
  sel_type     sel;
  logic [15:0] phys_addr;

  always_comb begin
    normal_mode = (mode_r == MODE_SINGLE) || (mode_r == MODE_EXPANDED);
    bus_mode    = (mode_r == MODE_EXPANDED) || (mode_r == MODE_TEST);
    ram_base    = {ram_page_r, PAGE_ZERO_OFS};
    reg_base    = {reg_page_r, PAGE_ZERO_OFS};
    eeprom_page_field = config_byte[CFG_EE_LSB +: 4];
    if (bus_mode) begin
      ee_base = {eeprom_page_field, EE_PAGE_OFS};
      ee_on   = (mode_r == MODE_TEST) ? ee_en_r : config_byte[CFG_EEON_BIT];
    end else begin
      ee_base = {EE_PAGE_DEF, EE_PAGE_OFS};
      ee_on   = 1'b1;
    end
    hole_base = {eeprom_page_field, HOLE_PAGE_OFS};
    cpu_addr  = cpu_req_i.addr;
    if (cpu_req_i.direct) begin
      cpu_addr = ram_base + {8'h00, cpu_req_i.addr[7:0]};
    end else if (cpu_req_i.vector && mode_r == MODE_BOOT) begin
      cpu_addr = BOOT_VEC_BASE | {10'h000, cpu_req_i.addr[VEC_OFS_W-1:0]};
    end
  end

  window_match u_ram_win (
    .addr_i   (cpu_addr),
    .base_i   (ram_base),
    .size_i   (RAM_SIZE),
    .enable_i (!stop_r),
    .hit_o    (hit_ram)
  );

  window_match u_reg_win (
    .addr_i   (cpu_addr),
    .base_i   (reg_base),
    .size_i   (REG_SIZE),
    .enable_i (1'b1),
    .hit_o    (hit_reg)
  );

  window_match u_ee_win (
    .addr_i   (cpu_addr),
    .base_i   (ee_base),
    .size_i   (EE_SIZE),
    .enable_i (ee_on),
    .hit_o    (hit_ee)
  );

  window_match u_boot_win (
    .addr_i   (cpu_addr),
    .base_i   (BOOT_BASE),
    .size_i   (BOOT_SIZE),
    .enable_i (mode_r == MODE_BOOT),
    .hit_o    (hit_boot)
  );

  window_match u_hole_win (
    .addr_i   (cpu_addr),
    .base_i   (hole_base),
    .size_i   (HOLE_SIZE),
    .enable_i (mode_r == MODE_TEST),
    .hit_o    (hit_hole)
  );

  always_comb begin
    sel        = '0;
    phys_addr  = cpu_addr;
    if (cpu_req_i.valid) begin
      if (cpu_req_i.vector && mode_r == MODE_TEST) begin
        sel.ext = 1'b1;
      end else if (hit_reg) begin
        sel.regs = 1'b1;
        phys_addr = cpu_addr - reg_base;
      end else if (hit_ram) begin
        sel.ram = 1'b1;
        phys_addr = cpu_addr - ram_base;
      end else if (hit_boot) begin
        sel.boot = 1'b1;
        phys_addr = cpu_addr - BOOT_BASE;
      end else if (hit_ee) begin
        sel.eeprom = 1'b1;
        phys_addr = cpu_addr - ee_base;
      end else if (bus_mode && !hit_hole) begin
        sel.ext = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expansion ports

  logic [7:0] pb_nxt;
  logic [7:0] pb_oe_n_nxt;
  logic [7:0] pf_nxt;
  logic [7:0] pf_oe_n_nxt;
  logic [7:0] pc_nxt;
  logic [7:0] pc_oe_n_nxt;
  logic       rw_n_nxt;
  logic [7:0] pb_r;
  logic [7:0] pb_oe_n_r;
  logic [7:0] pf_r;
  logic [7:0] pf_oe_n_r;
  logic [7:0] pc_r;
  logic [7:0] pc_oe_n_r;
  logic       rw_n_r;
  logic [7:0] ext_rdata_r;
  sel_type    sel_r;
  logic [15:0] mapped_r;

  always_comb begin
    if (bus_mode) begin
      pb_nxt      = phys_addr[15:8];
      pb_oe_n_nxt = 8'h00;
      pf_nxt      = phys_addr[7:0];
      pf_oe_n_nxt = 8'h00;
      pc_nxt      = cpu_req_i.wdata;
      pc_oe_n_nxt = (sel.ext && cpu_req_i.write) ? 8'h00 : 8'hff;
      rw_n_nxt    = !(sel.ext && cpu_req_i.write);
    end else begin
      pb_nxt      = gpio_b_out_i;
      pb_oe_n_nxt = ~gpio_b_dir_i;
      pf_nxt      = gpio_f_out_i;
      pf_oe_n_nxt = ~gpio_f_dir_i;
      pc_nxt      = gpio_c_out_i;
      pc_oe_n_nxt = ~gpio_c_dir_i;
      rw_n_nxt    = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pb_r        <= 8'h00;
      pb_oe_n_r   <= 8'hff;
      pf_r        <= 8'h00;
      pf_oe_n_r   <= 8'hff;
      pc_r        <= 8'h00;
      pc_oe_n_r   <= 8'hff;
      rw_n_r      <= 1'b1;
      ext_rdata_r <= 8'h00;
      sel_r       <= '0;
      mapped_r    <= 16'h0000;
    end else begin
      pb_r        <= pb_nxt;
      pb_oe_n_r   <= pb_oe_n_nxt;
      pf_r        <= pf_nxt;
      pf_oe_n_r   <= pf_oe_n_nxt;
      pc_r        <= pc_nxt;
      pc_oe_n_r   <= pc_oe_n_nxt;
      rw_n_r      <= rw_n_nxt;
      ext_rdata_r <= port_c_i;
      sel_r       <= sel;
      mapped_r    <= phys_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bootloader exit and serial pin

  logic [31:0] idle_cnt_r;
  logic [31:0] idle_cnt_nxt;
  logic        jump_r;
  logic        jump_nxt;
  logic        last_byte;

  always_comb begin
    last_byte     = sel.ram && cpu_req_i.write && phys_addr == RAM_LAST;
    idle_cnt_nxt  = idle_cnt_r;
    boot_done_nxt = boot_done_r;
    jump_nxt      = 1'b0;
    if (mode_r == MODE_BOOT && captured_r && !boot_done_r) begin
      idle_cnt_nxt = rx_byte_i ? 32'h0 : idle_cnt_r + 32'h1;
      if (last_byte || idle_cnt_r == 32'(IDLE_LIMIT - 1)) begin
        boot_done_nxt = 1'b1;
        jump_nxt      = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_cnt_r  <= 32'h0;
      boot_done_r <= 1'b0;
      jump_r      <= 1'b0;
    end else begin
      idle_cnt_r  <= idle_cnt_nxt;
      boot_done_r <= boot_done_nxt;
      jump_r      <= jump_nxt;
    end
  end

  assign boot_jump_o      = jump_r;
  assign boot_entry_o     = RAM_ENTRY;
  assign vectors_in_ram_o = (mode_r == MODE_BOOT);
  assign txd_o            = 1'b0;
  assign txd_oe_n_o       = (mode_r == MODE_BOOT) ? txd_data_i : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite register slave

  logic       dp_wr_r;
  logic       dp_wr_nxt;
  logic [3:0] dp_addr_r;
  logic [3:0] dp_addr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic       ap_valid;

  always_comb begin
    ap_valid    = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
    dp_wr_nxt   = ap_valid && hwrite_i && hsize_i == HSIZE_WORD;
    dp_addr_nxt = haddr_i[3:0];
    rdata_nxt   = 32'h0;
    if (ap_valid && !hwrite_i) begin
      unique case (haddr_i[3:0])
        INIT_OFS:   rdata_nxt = {24'h0, ram_page_r, reg_page_r};
        CONFIG_OFS: rdata_nxt = {24'h0, config_byte};
        STATUS_OFS: rdata_nxt = 32'({ee_on, boot_done_r, stop_r, mode_r});
        default:    rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 4'h0;
      rdata_r   <= 32'h0;
    end else begin
      dp_wr_r   <= dp_wr_nxt;
      dp_addr_r <= dp_addr_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign wr_init     = dp_wr_r && dp_addr_r == INIT_OFS;
  assign wr_config   = dp_wr_r && dp_addr_r == CONFIG_OFS;
  assign wr_control  = dp_wr_r && dp_addr_r == CONTROL_OFS;
  assign hrdata_o    = rdata_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sel_o         = sel_r;
  assign mapped_addr_o = mapped_r;
  assign ext_rdata_o   = ext_rdata_r;
  assign port_b_o      = pb_r;
  assign port_b_oe_n_o = pb_oe_n_r;
  assign port_f_o      = pf_r;
  assign port_f_oe_n_o = pf_oe_n_r;
  assign port_c_o      = pc_r;
  assign port_c_oe_n_o = pc_oe_n_r;
  assign rw_n_o        = rw_n_r;
  assign clk_halt_o    = stop_r;
  assign mode_o        = mode_r;

endmodule : mode_select_memory_map_decoder

// ---- verif/mode_map_checker.sv ----
`timescale 1ns/1ns
module mode_map_checker (
  input wire logic                      clk_i,
  input wire logic                      rst_n_i,
  input wire mode_map_pkg::cpu_req_type cpu_req_i,
  input wire mode_map_pkg::sel_type     sel_o,
  input wire logic [15:0]               mapped_addr_o,
  input wire logic [7:0]                port_b_o,
  input wire logic [7:0]                port_b_oe_n_o,
  input wire logic [7:0]                port_f_o,
  input wire logic [7:0]                gpio_b_dir_i,
  input wire logic                      rw_n_o,
  input wire logic                      txd_data_i,
  input wire logic                      txd_o,
  input wire logic                      txd_oe_n_o,
  input wire logic                      vectors_in_ram_o,
  input wire logic                      boot_jump_o,
  input wire mode_map_pkg::op_mode_type mode_o
);
  import mode_map_pkg::*;
  logic [1:0] up_r;
  logic       live;
  ////////////////////////////////////////////////////////////////////////////
  // Edges since reset release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) up_r <= 2'h0;
    else if (!up_r[1]) up_r <= up_r + 2'h1;
  end
  assign live = up_r[1];
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence req_s; live && cpu_req_i.valid; endsequence
  sequence vec_s; req_s ##0 cpu_req_i.vector; endsequence
  single_gpio_a:
    assert property (live && mode_o == MODE_SINGLE |=> port_b_oe_n_o == ~$past(gpio_b_dir_i))
    else $error("port b direction wrong in single chip mode");
  exp_pins_a:
    assert property (live && mode_o == MODE_EXPANDED && sel_o.ext |-> port_b_oe_n_o == 8'h00
      && port_b_o == mapped_addr_o[15:8] && port_f_o == mapped_addr_o[7:0])
    else $error("expansion address pins wrong");
  rw_dir_a:
    assert property (req_s |=> !sel_o.ext || rw_n_o == !$past(cpu_req_i.write))
    else $error("read write pin wrong");
  boot_vec_a:
    assert property (vec_s ##0 mode_o == MODE_BOOT |=> sel_o.boot
      && mapped_addr_o == (16'h00c0 | ($past(cpu_req_i.addr) & 16'h003f)))
    else $error("boot vector not from top of boot rom");
  jump_pulse_a:
    assert property (boot_jump_o |-> mode_o == MODE_BOOT ##1 !boot_jump_o)
    else $error("boot jump not a single pulse");
  txd_od_a:
    assert property (live && mode_o == MODE_BOOT |-> !txd_o && vectors_in_ram_o
      && txd_oe_n_o == txd_data_i)
    else $error("boot serial pin not open drain");
  sel_one_a:
    assert property (live |-> $onehot0(sel_o))
    else $error("more than one select");
  boot_only_a:
    assert property (sel_o.boot |-> mode_o == MODE_BOOT)
    else $error("boot rom selected outside boot mode");
  test_vec_a:
    assert property (vec_s ##0 mode_o == MODE_TEST |=> sel_o.ext)
    else $error("test mode vector not external");
endmodule : mode_map_checker

// ---- verif/ext_mem.sv ----
`timescale 1ns/1ns
module ext_mem (
  input  wire logic       clk_i,
  input  wire logic [7:0] bus_hi_i,
  input  wire logic [7:0] bus_lo_i,
  input  wire logic [7:0] data_i,
  input  wire logic [7:0] data_oe_n_i,
  input  wire logic       rw_n_i,
  output logic      [7:0] data_o
);
  logic [7:0] mem [0:255];
  logic [7:0] last;
  // Store on external write, address from both ports
  always @(posedge clk_i) begin
    if (!rw_n_i && data_oe_n_i == 8'h00) mem[bus_hi_i ^ bus_lo_i] <= data_i;
    last <= data_o;
  end
  // Drive only while the device reads; otherwise a changing pattern
  assign data_o = (rw_n_i && data_oe_n_i == 8'hff) ? mem[bus_hi_i ^ bus_lo_i] : ~last;
endmodule : ext_mem

// ---- verif/mode_select_memory_map_decoder_test.sv ----
`timescale 1ns/1ns
module mode_select_memory_map_decoder_test;
  import mode_map_pkg::*;
  localparam int LIM = 20;
  logic clk_i = 1'h0, rst_n_i = 1'h0, mode_select_a_i = 1'h0, mode_select_b_i = 1'h0;
  logic hsel_i = 1'h0, hwrite_i = 1'h0, hreadyout_o, hresp_o, rw_n_o, txd_o, txd_oe_n_o, txd_w;
  logic txd_data_i = 1'h0, rx_byte_i = 1'h0, wake_i = 1'h0;
  logic boot_jump_o, vectors_in_ram_o, clk_halt_o;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
  logic [1:0]  htrans_i = 2'h0;
  logic [2:0]  hsize_i = 3'h0;
  logic [7:0]  gpio_b_out_i = 8'h0, gpio_b_dir_i = 8'h0, gpio_f_out_i = 8'h0;
  logic [7:0]  gpio_f_dir_i = 8'h0, gpio_c_out_i = 8'h0, gpio_c_dir_i = 8'h0, wd;
  logic [7:0]  port_c_i, port_b_o, port_b_oe_n_o, port_f_o, port_f_oe_n_o, port_c_o;
  logic [7:0]  port_c_oe_n_o, ext_rdata_o;
  logic [15:0] mapped_addr_o, boot_entry_o, a;
  logic [3:0]  rampg, regpg, eepg;
  logic        eeon, v, dr;
  cpu_req_type cpu_req_i = '0;
  sel_type     sel_o;
  op_mode_type mode_o, md;
  int          err_count = 0, tests_run = 0;
  logic [15:0] corner [10] = '{16'h0000, 16'h03ff, 16'h0400, 16'h1000, 16'h105f, 16'h1060,
                               16'hfe00, 16'hffff, 16'hbf00, 16'hfd10};
  always #10 clk_i = ~clk_i;
  assign txd_w = txd_oe_n_o ? 1'h1 : txd_o;
  mode_select_memory_map_decoder #(.IDLE_LIMIT(LIM)) dut (.clk_i, .rst_n_i, .mode_select_a_i,
    .mode_select_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .cpu_req_i, .sel_o, .mapped_addr_o,
    .ext_rdata_o, .gpio_b_out_i, .gpio_b_dir_i, .gpio_f_out_i, .gpio_f_dir_i, .gpio_c_out_i,
    .gpio_c_dir_i, .port_c_i, .port_b_o, .port_b_oe_n_o, .port_f_o, .port_f_oe_n_o, .port_c_o,
    .port_c_oe_n_o, .rw_n_o, .txd_data_i, .rx_byte_i, .txd_o, .txd_oe_n_o, .boot_jump_o,
    .boot_entry_o, .vectors_in_ram_o, .clk_halt_o, .wake_i, .mode_o);
  ext_mem far (.clk_i, .bus_hi_i(port_b_o), .bus_lo_i(port_f_o), .data_i(port_c_o),
    .data_oe_n_i(port_c_oe_n_o), .rw_n_i(rw_n_o), .data_o(port_c_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic sel_type decode(input logic [15:0] ai, input logic vi, input logic di);
    sel_type     s;
    logic [15:0] x;
    s = '0;
    x = di ? {rampg, 4'h0, ai[7:0]} : ai;
    if (vi && md == MODE_BOOT) x = BOOT_VEC_BASE | {10'h0, ai[5:0]};
    if (vi && md == MODE_TEST) s.ext = 1'h1;
    else if (x[15:12] == regpg && x[11:0] < 12'h060) s.regs = 1'h1;
    else if (x[15:12] == rampg && x[11:0] < 12'h400) s.ram = 1'h1;
    else if (md == MODE_BOOT && x[15:8] == 8'hbf) s.boot = 1'h1;
    else if (eeon && x[15:12] == eepg && x[11:9] == 3'h7) s.eeprom = 1'h1;
    else s.ext = (md == MODE_EXPANDED) || (md == MODE_TEST && !(x[15:12] == eepg && x[11:8] == 4'hd));
    return s;
  endfunction : decode
  task automatic rst(input logic [1:0] p);
    rst_n_i <= 1'h0;
    {mode_select_b_i, mode_select_a_i} <= p;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    md = op_mode_type'(p);
    {rampg, regpg, eepg, eeon} = {RAM_PAGE_RST, REG_PAGE_RST, EE_PAGE_DEF, md != MODE_TEST};
    #1 chk(32'(mode_o), 32'(md));
  endtask : rst
  task automatic cpu(input logic [15:0] ai, input logic w, input logic vi, input logic di);
    @(posedge clk_i);
    cpu_req_i <= '{1'h1, w, vi, di, ai, 8'($urandom)};
    {gpio_b_out_i, gpio_b_dir_i, gpio_f_out_i, gpio_f_dir_i} <= $urandom;
    {gpio_c_out_i, gpio_c_dir_i, txd_data_i} <= 17'($urandom);
    @(posedge clk_i);
    cpu_req_i.valid <= 1'h0;
    #1 chk(32'(sel_o), 32'(decode(ai, vi, di)));
    if (md == MODE_SINGLE) chk({port_f_o, port_c_oe_n_o, port_f_oe_n_o, port_c_o},
      {gpio_f_out_i, ~gpio_c_dir_i, ~gpio_f_dir_i, gpio_c_out_i});
    if (md == MODE_BOOT) chk(32'(txd_w), 32'(txd_data_i));
  endtask : cpu
  task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] wdat);
    int n;
    n = 0;
    @(posedge clk_i);
    hsel_i <= 1'h1;
    haddr_i <= ad;
    htrans_i <= HTRANS_NONSEQ;
    hwrite_i <= w;
    hsize_i <= HSIZE_WORD;
    do begin @(posedge clk_i); n++; end while (hreadyout_o !== 1'h1 && n < 20);
    htrans_i <= 2'h0;
    hwdata_i <= wdat;
    do begin @(posedge clk_i); n++; end while (hreadyout_o !== 1'h1 && n < 40);
    rd = hrdata_o;
    if (n >= 40) begin err_count++; conclude(); end
  endtask : ahb
  task automatic wait_jump(input int lim, input logic want);
    int n;
    n = 0;
    while (boot_jump_o !== 1'h1 && n < lim) begin @(posedge clk_i); #1 n++; end
    chk(32'(boot_jump_o), 32'(want));
  endtask : wait_jump
  ////////////////////////////////////////////////////////////////////////////
  initial begin #1000000; err_count++; conclude(); end
  initial begin
    void'($urandom(32'h213dee33));
    for (int p = 0; p < 4; p++) begin
      rst(2'(p));
      foreach (corner[k]) cpu(corner[k], 1'h0, 1'h0, 1'h0);
      repeat (25) begin
        v = $urandom_range(0, 3) == 0;
        dr = !v && $urandom_range(0, 3) == 0;
        a = v ? {10'h3ff, 6'($urandom)} : 16'($urandom);
        cpu(a, 1'($urandom), v, dr);
      end
      ahb(1'h0, 32'(STATUS_OFS), 32'h0);
      chk(rd, {27'h0, eeon, md == MODE_BOOT, 1'h0, md});
      ahb(1'h0, 32'(CONTROL_OFS), 32'h0);
      chk(rd, 32'h0);
    end
    ahb(1'h1, 32'(INIT_OFS), 32'h22);
    {rampg, regpg} = 8'h22;
    foreach (corner[k]) cpu(corner[k] ^ 16'h3000, 1'h0, 1'h0, 1'h0);
    cpu(16'h4321, 1'h1, 1'h0, 1'h0);
    wd = cpu_req_i.wdata;
    cpu(16'h4321, 1'h0, 1'h0, 1'h0);
    @(posedge clk_i);
    #1 chk(32'(ext_rdata_o), 32'(wd));
    rst(2'h1);
    ahb(1'h1, 32'(CONFIG_OFS), 32'h31);
    {eepg, eeon} = 5'h7;
    foreach (corner[k]) cpu(corner[k] ^ 16'hc000, 1'h0, 1'h0, 1'h0);
    ahb(1'h0, 32'(CONFIG_OFS), 32'h0);
    chk(rd & 32'hf1, 32'h31);
    rst(2'h2);
    ahb(1'h1, 32'(CONTROL_OFS), 32'h1);
    #1 chk(32'(clk_halt_o), 32'h1);
    @(posedge clk_i);
    wake_i <= 1'h1;
    @(posedge clk_i);
    wake_i <= 1'h0;
    #1 chk(32'(clk_halt_o), 32'h0);
    rst(2'h0);
    @(posedge clk_i);
    rx_byte_i <= 1'h1;
    wait_jump(LIM + 4, 1'h0);
    @(posedge clk_i);
    rx_byte_i <= 1'h0;
    wait_jump(LIM + 4, 1'h1);
    cpu(RAM_LAST, 1'h1, 1'h0, 1'h0);
    wait_jump(12, 1'h0);
    rst(2'h0);
    cpu(RAM_LAST, 1'h1, 1'h0, 1'h0);
    wait_jump(3, 1'h1);
    chk(32'(boot_entry_o), 32'(RAM_ENTRY));
    conclude();
  end
endmodule : mode_select_memory_map_decoder_test
bind mode_select_memory_map_decoder mode_map_checker watch (.clk_i, .rst_n_i, .cpu_req_i, .sel_o,
  .mapped_addr_o, .port_b_o, .port_b_oe_n_o, .port_f_o, .gpio_b_dir_i, .rw_n_o, .txd_data_i,
  .txd_o, .txd_oe_n_o, .vectors_in_ram_o, .boot_jump_o, .mode_o);
